// ==== logic/sspr_ctrl.sv ====
// supply supervisor, voltage monitor and regulator mode controller
// What this block does
// [RQ1] hold internal reset while supply is below active reset threshold
// [RQ2] above active reset threshold (brownout level 1 after system reset), load option byte: thresholds or brownout off
// [RQ3] five brownout thresholds chosen by option byte, not by register
// [RQ4] software enables monitor and picks one of seven levels
// [RQ5] monitor interrupts on falling, rising or both crossings
// [RQ6] optionally switch internal reference off while in Stop
// [RQ7] start-up delay 3.3 ms with brownout, 1 ms without brownout or after a Standby wakeup
// [RQ8] three regulator modes; main regulator in Run
// [RQ9] low-power regulator in low-power run, low-power sleep, Stop
// [RQ10] power-down in Standby; only standby domain survives
// [RQ11] Stop: start fast oscillator on peripheral request, route, stop
// [RQ12] processor deep-sleep request enters Stop or Standby
// [RQ13] two-stage synchronise every comparator output before use
`timescale 1ns/10ps
module sspr_ctrl
  import sspr_pkg::*;
#(
  parameter int START_BOR_CYC = SSPR_START_BOR_CYC,
  parameter int START_NOBOR_CYC = SSPR_START_NOBOR_CYC,
  parameter int N_REQ = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic por_ok,
  input wire logic brownout_ok,
  input wire logic monitor_above,
  input wire logic [2:0] opt_brownout,
  input wire logic deep_sleep_req,
  input wire logic wakeup,
  input wire logic lp_sleep,
  input wire logic [N_REQ-1:0] osc_req,
  output logic internal_rst,
  output logic [2:0] brownout_level,
  output logic brownout_enable,
  output logic monitor_enable,
  output logic [2:0] monitor_level,
  output logic internal_reference_voltage_on,
  output logic [1:0] regulator_mode,
  output logic fast_internal_oscillator_on,
  output logic [N_REQ-1:0] osc_gate,
  output logic irq
);
  // refuse sizes the counter and gate vector cannot hold
  if (N_REQ < 1 || N_REQ > 16) begin : g_req_chk
    $error("N_REQ out of range");
  end
  if (START_BOR_CYC >= (1 << SSPR_CNT_W)) begin : g_bor_chk
    $error("count too wide");
  end
  if (START_NOBOR_CYC >= (1 << SSPR_CNT_W)) begin : g_nobor_chk
    $error("count too wide");
  end
  if (START_NOBOR_CYC < 1 || START_BOR_CYC < 1) begin : g_min_chk
    $error("start count too small");
  end

  function automatic logic [1:0] reg_mode_of(input sspr_state_t s);
    case (s)
      SSPR_ST_RUN: reg_mode_of = SSPR_REG_MAIN; // [RQ8]
      SSPR_ST_LPRUN, SSPR_ST_STOP: reg_mode_of = SSPR_REG_LOW; // [RQ9]
      SSPR_ST_STBY: reg_mode_of = SSPR_REG_DOWN; // [RQ10]
      default: reg_mode_of = SSPR_REG_MAIN;
    endcase
  endfunction

  typedef struct packed {
    sspr_state_t st;
    logic [SSPR_CNT_W-1:0] cnt;
    logic [2:0] bor_lvl;
    logic bor_en;
    logic [SSPR_CTRL_W-1:0] ctrl;
    logic [SSPR_IRQ_W-1:0] irq_en;
    logic [SSPR_IRQ_W-1:0] irq_st;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic mon_prev;
    logic [N_REQ-1:0] gate;
    logic osc_on;
    logic [31:0] rdata;
    logic rst_o;
    logic [1:0] rmode;
    logic vref;
    logic irq_o;
  } sspr_regs_t;

  sspr_regs_t r_reg, r_next;
  logic supply_ok;
  logic mon_rise;
  logic mon_fall;

  // sy1 feeds only sy2
  assign supply_ok = r_reg.sy2[0] & (~r_reg.bor_en | r_reg.sy2[1]); // [RQ13]
  assign mon_rise = r_reg.sy2[2] & ~r_reg.mon_prev;
  assign mon_fall = ~r_reg.sy2[2] & r_reg.mon_prev;

  always_comb begin
    r_next = r_reg;
    r_next.sy1 = {monitor_above, brownout_ok, por_ok};
    r_next.sy2 = r_reg.sy1; // [RQ13]
    r_next.mon_prev = r_reg.sy2[2];
    if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    case (r_reg.st)
      SSPR_ST_RESET: begin
        if (supply_ok) begin
          r_next.st = SSPR_ST_LOAD; // [RQ2]
          r_next.cnt = SSPR_CNT_W'(SSPR_LOAD_CYC);
        end
      end
      SSPR_ST_LOAD: begin
        if (r_reg.cnt == '0) begin
          // option byte decides thresholds, or turns brownout off until the next option load
          r_next.bor_en = (opt_brownout != SSPR_BOR_OFF); // [RQ2]
          r_next.bor_lvl = (opt_brownout > SSPR_BOR_MAX) ?
            SSPR_BOR_MAX : opt_brownout; // [RQ3]
          r_next.st = SSPR_ST_START;
          r_next.cnt = (opt_brownout != SSPR_BOR_OFF) ?
            SSPR_CNT_W'(START_BOR_CYC) :
            SSPR_CNT_W'(START_NOBOR_CYC); // [RQ7]
        end
      end
      SSPR_ST_START: begin
        if (r_reg.cnt == '0) begin
          r_next.st = SSPR_ST_RUN;
        end
      end
      SSPR_ST_RUN, SSPR_ST_LPRUN: begin
        r_next.st = (r_reg.ctrl[SSPR_CTRL_MODE_LSB+:2] == SSPR_PM_LPRUN) ?
          SSPR_ST_LPRUN : SSPR_ST_RUN;
        // held for the whole sleep, not toggled back by the mode field
        if (lp_sleep) begin
          r_next.st = SSPR_ST_LPRUN; // [RQ9]
        end
        if (deep_sleep_req) begin
          r_next.st = (r_reg.ctrl[SSPR_CTRL_MODE_LSB+:2] == SSPR_PM_STANDBY) ?
            SSPR_ST_STBY : SSPR_ST_STOP; // [RQ12]
        end
      end
      SSPR_ST_STOP: begin
        if (wakeup) begin
          r_next.st = SSPR_ST_RUN;
        end
      end
      SSPR_ST_STBY: begin
        // leaving standby is a fresh start: volatile state is lost
        if (wakeup) begin
          r_next.st = SSPR_ST_START; // [RQ10]
          r_next.cnt = SSPR_CNT_W'(START_NOBOR_CYC);
          r_next.ctrl = SSPR_CTRL_RST;
          r_next.irq_en = '0;
          r_next.irq_st = '0;
        end
      end
      default: r_next.st = SSPR_ST_RESET;
    endcase
    // registers
    if (reg_wr) begin
      case (reg_addr)
        SSPR_OFS_CTRL: begin
          r_next.ctrl = reg_wdata[SSPR_CTRL_W-1:0];
          if (reg_wdata[SSPR_CTRL_LVL_LSB+:3] > SSPR_LVL_MAX) begin
            r_next.ctrl[SSPR_CTRL_LVL_LSB+:3] = SSPR_LVL_MAX; // [RQ4]
          end
        end
        SSPR_OFS_IRQ_EN: r_next.irq_en = reg_wdata[SSPR_IRQ_W-1:0];
        SSPR_OFS_IRQ_CLR: r_next.irq_st = r_reg.irq_st &
          ~reg_wdata[SSPR_IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    if (r_reg.ctrl[SSPR_CTRL_MON_EN]) begin
      if (mon_fall) r_next.irq_st[SSPR_IRQ_FALL] = 1'b1; // [RQ5]
      if (mon_rise) r_next.irq_st[SSPR_IRQ_RISE] = 1'b1; // [RQ5]
    end
    r_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        SSPR_OFS_CTRL: r_next.rdata = {25'h0, r_reg.ctrl};
        SSPR_OFS_STAT: r_next.rdata = {22'h0, r_reg.st,
          r_reg.bor_en, r_reg.bor_lvl, r_reg.sy2[2], r_reg.irq_st};
        SSPR_OFS_IRQ_EN: r_next.rdata = {30'h0, r_reg.irq_en};
        default: r_next.rdata = '0;
      endcase
    end
    // fast oscillator only to requesters, only while stopped
    for (int i = 0; i < N_REQ; i++) begin
      r_next.gate[i] = (r_next.st == SSPR_ST_STOP) & osc_req[i]; // [RQ11]
    end
    r_next.osc_on = |r_next.gate;
    r_next.rst_o = ~(r_next.st inside {SSPR_ST_RUN, SSPR_ST_LPRUN,
      SSPR_ST_STOP, SSPR_ST_STBY}); // [RQ1]
    r_next.rmode = reg_mode_of(r_next.st);
    r_next.vref = ~(r_next.st == SSPR_ST_STOP &&
      r_next.ctrl[SSPR_CTRL_VREF_OFF]); // [RQ6]
    r_next.irq_o = |(r_next.irq_st & r_next.irq_en);
    // any supply drop overrides everything
    if (!supply_ok) begin
      r_next.st = SSPR_ST_RESET; // [RQ1]
      r_next.rst_o = 1'b1;
      r_next.rmode = SSPR_REG_MAIN;
      r_next.gate = '0;
      r_next.osc_on = 1'b0;
      r_next.ctrl = SSPR_CTRL_RST;
      r_next.irq_en = '0;
      r_next.irq_st = '0;
      r_next.irq_o = 1'b0;
      r_next.vref = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '{st: SSPR_ST_RESET, rst_o: 1'b1, vref: 1'b1,
        rmode: SSPR_REG_MAIN, bor_en: 1'b1, bor_lvl: SSPR_BOR_LVL_RST,
        ctrl: SSPR_CTRL_RST, default: '0};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign internal_rst = r_reg.rst_o;
  assign brownout_level = r_reg.bor_lvl;
  assign brownout_enable = r_reg.bor_en;
  assign monitor_enable = r_reg.ctrl[SSPR_CTRL_MON_EN]; // [RQ4]
  assign monitor_level = r_reg.ctrl[SSPR_CTRL_LVL_LSB+:3];
  assign internal_reference_voltage_on = r_reg.vref;
  assign regulator_mode = r_reg.rmode;
  assign fast_internal_oscillator_on = r_reg.osc_on; // [RQ11]
  assign osc_gate = r_reg.gate;
  assign irq = r_reg.irq_o;

  rst_held_a: assert property ( // [RQ1]
    @(posedge clk) disable iff (sys_rst)
    clk_en && !supply_ok |=> internal_rst)
    else $error("reset not held on low supply");
  load_first_a: assert property ( // [RQ2]
    @(posedge clk) disable iff (sys_rst)
    clk_en && r_reg.st == SSPR_ST_RESET && supply_ok |=>
    r_reg.st == SSPR_ST_LOAD) else $error("no option load");
  bor_range_a: assert property ( // [RQ3]
    @(posedge clk) disable iff (sys_rst)
    brownout_level <= SSPR_BOR_MAX)
    else $error("brownout level out of range");
  mon_level_a: assert property ( // [RQ4]
    @(posedge clk) disable iff (sys_rst)
    monitor_level <= SSPR_LVL_MAX)
    else $error("monitor level out of range");
  fall_flag_a: assert property ( // [RQ5]
    @(posedge clk) disable iff (sys_rst)
    clk_en && monitor_enable && mon_fall && supply_ok |=>
    r_reg.irq_st[SSPR_IRQ_FALL]) else $error("fall lost");
  rise_flag_a: assert property ( // [RQ5]
    @(posedge clk) disable iff (sys_rst)
    clk_en && monitor_enable && mon_rise && supply_ok |=>
    r_reg.irq_st[SSPR_IRQ_RISE]) else $error("rise lost");
  vref_stop_a: assert property ( // [RQ6]
    @(posedge clk) disable iff (sys_rst)
    r_reg.st == SSPR_ST_STOP && r_reg.ctrl[SSPR_CTRL_VREF_OFF] |->
    !internal_reference_voltage_on) else $error("reference on");
  start_wait_a: assert property ( // [RQ7]
    @(posedge clk) disable iff (sys_rst)
    $rose(r_reg.st == SSPR_ST_START) |-> r_reg.cnt != '0)
    else $error("start delay skipped");
  reg_mode_a: assert property ( // [RQ8]
    @(posedge clk) disable iff (sys_rst)
    r_reg.st == SSPR_ST_RUN |-> regulator_mode == SSPR_REG_MAIN)
    else $error("run not main");
  stop_low_a: assert property ( // [RQ9]
    @(posedge clk) disable iff (sys_rst)
    r_reg.st == SSPR_ST_STOP |-> regulator_mode == SSPR_REG_LOW)
    else $error("stop not low");
  lp_sleep_a: assert property ( // [RQ9]
    @(posedge clk) disable iff (sys_rst)
    clk_en && supply_ok && lp_sleep && !deep_sleep_req &&
    r_reg.st inside {SSPR_ST_RUN, SSPR_ST_LPRUN} |=>
    regulator_mode == SSPR_REG_LOW) else $error("sleep not low");
  stby_down_a: assert property ( // [RQ10]
    @(posedge clk) disable iff (sys_rst)
    r_reg.st == SSPR_ST_STBY |-> regulator_mode == SSPR_REG_DOWN)
    else $error("standby not down");
  stby_exit_a: assert property ( // [RQ10]
    @(posedge clk) disable iff (sys_rst)
    clk_en && supply_ok && !reg_wr && wakeup && r_reg.st == SSPR_ST_STBY |=>
    r_reg.st == SSPR_ST_START && r_reg.ctrl == SSPR_CTRL_RST)
    else $error("standby exit kept state");
  osc_off_a: assert property ( // [RQ11]
    @(posedge clk) disable iff (sys_rst)
    r_reg.st != SSPR_ST_STOP |-> osc_gate == '0)
    else $error("oscillator outside stop");
  osc_route_a: assert property ( // [RQ11]
    @(posedge clk) disable iff (sys_rst)
    clk_en && supply_ok && !wakeup && r_reg.st == SSPR_ST_STOP |=>
    osc_gate == $past(osc_req)) else $error("oscillator misrouted");
  deep_sleep_a: assert property ( // [RQ12]
    @(posedge clk) disable iff (sys_rst)
    clk_en && supply_ok && deep_sleep_req &&
    r_reg.st inside {SSPR_ST_RUN, SSPR_ST_LPRUN} |=>
    r_reg.st inside {SSPR_ST_STOP, SSPR_ST_STBY})
    else $error("sleep request ignored");
endmodule

// ==== logic/sspr_pkg.sv ====
// constants and types shared by the supply supervisor controller
package sspr_pkg;
  localparam int SSPR_CLK_MHZ = 250;
  localparam int SSPR_START_BOR_US = 3300;
  localparam int SSPR_START_NOBOR_US = 1000;
  localparam int SSPR_START_BOR_CYC = SSPR_START_BOR_US * SSPR_CLK_MHZ;
  localparam int SSPR_START_NOBOR_CYC = SSPR_START_NOBOR_US * SSPR_CLK_MHZ;
  localparam int SSPR_CNT_W = 20;
  localparam int SSPR_LOAD_CYC = 16;
  // register offsets
  localparam logic [3:0] SSPR_OFS_CTRL = 4'h0;
  localparam logic [3:0] SSPR_OFS_STAT = 4'h4;
  localparam logic [3:0] SSPR_OFS_IRQ_EN = 4'h8;
  localparam logic [3:0] SSPR_OFS_IRQ_CLR = 4'hc;
  localparam logic [3:0] SSPR_OFS_IRQ_ST = 4'h4;
  // control fields
  localparam int SSPR_CTRL_MON_EN = 0;
  localparam int SSPR_CTRL_LVL_LSB = 1;
  localparam int SSPR_CTRL_VREF_OFF = 4;
  localparam int SSPR_CTRL_MODE_LSB = 5;
  localparam int SSPR_CTRL_W = 7;
  localparam logic [6:0] SSPR_CTRL_RST = 7'h00;
  localparam logic [2:0] SSPR_LVL_MAX = 3'h6;
  // interrupt bits
  localparam int SSPR_IRQ_FALL = 0;
  localparam int SSPR_IRQ_RISE = 1;
  localparam int SSPR_IRQ_W = 2;
  // brownout option: 0 disables, 1..5 thresholds
  localparam logic [2:0] SSPR_BOR_OFF = 3'h0;
  localparam logic [2:0] SSPR_BOR_MAX = 3'h5;
  localparam logic [2:0] SSPR_BOR_LVL_RST = 3'h1;
  typedef enum logic [1:0] {
    SSPR_REG_MAIN = 2'h0,
    SSPR_REG_LOW = 2'h1,
    SSPR_REG_DOWN = 2'h2
  } sspr_reg_mode_t;
  // requested power mode from software
  typedef enum logic [1:0] {
    SSPR_PM_STOP = 2'h0,
    SSPR_PM_STANDBY = 2'h1,
    SSPR_PM_LPRUN = 2'h2
  } sspr_pm_t;
  typedef enum logic [2:0] {
    SSPR_ST_RESET = 3'b000,
    SSPR_ST_LOAD = 3'b001,
    SSPR_ST_START = 3'b011,
    SSPR_ST_RUN = 3'b010,
    SSPR_ST_LPRUN = 3'b110,
    SSPR_ST_STOP = 3'b111,
    SSPR_ST_STBY = 3'b101
  } sspr_state_t;
endpackage

// ==== tb/sspr_analog.sv ====
// comparator and processor-side model facing the supervisor controller
`timescale 1ns/10ps
module sspr_analog
  import sspr_pkg::*;
(
  input wire logic clk,
  input wire integer supply_mv,
  input wire logic [2:0] brownout_level,
  input wire logic [2:0] monitor_level,
  input wire logic sleep_cmd,
  output logic por_ok,
  output logic brownout_ok,
  output logic monitor_above,
  output logic deep_sleep_req
);
  // thresholds in millivolts; brownout steps of 300 from 1800 at level 1
  always_ff @(posedge clk) begin
    por_ok <= supply_mv >= 1650;
    brownout_ok <= supply_mv >= 1500 + 300 * int'(brownout_level);
    monitor_above <= supply_mv >= 1850 + 200 * int'(monitor_level);
    deep_sleep_req <= sleep_cmd;
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the supply supervisor controller
`timescale 1ns/10ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module testbench;
  import sspr_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic por_ok, brownout_ok, monitor_above, deep_sleep_req, sleep_cmd = 0;
  logic wakeup = 0, lp_sleep = 0, internal_rst, brownout_enable, irq;
  logic [2:0] opt_brownout = 3'h1, brownout_level, monitor_level;
  logic [3:0] osc_req = 4'h0, osc_gate;
  logic monitor_enable, internal_reference_voltage_on;
  logic fast_internal_oscillator_on;
  logic [1:0] regulator_mode;
  int supply_mv = 1000, num_errors = 0, check_count = 0, cyc = 0, n;
  sspr_ctrl #(.START_BOR_CYC(40), .START_NOBOR_CYC(20), .N_REQ(4)) u_sspr_ctrl (
    .clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .por_ok, .brownout_ok, .monitor_above, .opt_brownout,
    .deep_sleep_req, .wakeup, .lp_sleep, .osc_req, .internal_rst,
    .brownout_level, .brownout_enable, .monitor_enable, .monitor_level,
    .internal_reference_voltage_on, .regulator_mode,
    .fast_internal_oscillator_on, .osc_gate, .irq);
  sspr_analog u_sspr_analog (.clk, .supply_mv, .brownout_level,
    .monitor_level, .sleep_cmd, .por_ok, .brownout_ok, .monitor_above,
    .deep_sleep_req);
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check_val(input logic [31:0] a, input logic [31:0] b);
    check_count++;
    if (a !== b) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, b);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pulse_sleep();
    @(posedge clk) sleep_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    sleep_cmd <= 1'b0;
  endtask
  task automatic t_power();
    repeat (50) @(posedge clk);
    `CHK(internal_rst, 1);
    supply_mv <= 3300;
    for (n = 0; n < 300 && internal_rst !== 1'b0; n++) @(negedge clk);
    `CHK(n >= 56 && n <= 66, 1);
    `CHK({brownout_enable, brownout_level}, 4'h9);
    `CHK(regulator_mode, SSPR_REG_MAIN);
    $display("power-up test done");
  endtask
  task automatic t_monitor();
    wr(SSPR_OFS_CTRL, 32'h0000_0005);
    wr(SSPR_OFS_IRQ_EN, 32'h0000_0003);
    `CHK({monitor_enable, monitor_level}, 4'hA);
    supply_mv <= 2000;
    repeat (8) @(posedge clk);
    rd(SSPR_OFS_STAT, d);
    `CHK({irq, d[1:0]}, 3'b101);
    wr(SSPR_OFS_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 0);
    supply_mv <= 3300;
    repeat (8) @(posedge clk);
    rd(SSPR_OFS_STAT, d);
    `CHK({irq, d[1:0]}, 3'b110);
    wr(SSPR_OFS_IRQ_CLR, 32'h0000_0003);
    wr(SSPR_OFS_CTRL, 32'h0000_000f);
    rd(SSPR_OFS_CTRL, d);
    `CHK(d[3:1], SSPR_LVL_MAX);
    $display("monitor test done");
  endtask
  task automatic t_stop();
    wr(SSPR_OFS_CTRL, 32'h0000_0010);
    pulse_sleep();
    `CHK(regulator_mode, SSPR_REG_LOW);
    `CHK(internal_reference_voltage_on, 0);
    osc_req <= 4'h2;
    repeat (3) @(posedge clk);
    `CHK({fast_internal_oscillator_on, osc_gate}, 5'h12);
    osc_req <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK({fast_internal_oscillator_on, osc_gate}, 5'h00);
    wakeup <= 1'b1;
    repeat (3) @(posedge clk);
    wakeup <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(regulator_mode, SSPR_REG_MAIN);
    `CHK({internal_reference_voltage_on, osc_gate}, 5'h10);
    lp_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(regulator_mode, SSPR_REG_LOW);
    lp_sleep <= 1'b0;
    repeat (3) @(posedge clk);
    wr(SSPR_OFS_CTRL, 32'h0000_0040);
    repeat (2) @(posedge clk);
    `CHK(regulator_mode, SSPR_REG_LOW);
    $display("stop test done");
  endtask
  task automatic t_standby();
    wr(SSPR_OFS_CTRL, 32'h0000_0020);
    pulse_sleep();
    `CHK(regulator_mode, SSPR_REG_DOWN);
    wakeup <= 1'b1;
    repeat (3) @(posedge clk);
    wakeup <= 1'b0;
    for (n = 0; n < 300 && internal_rst !== 1'b0; n++) @(negedge clk);
    `CHK(n >= 16 && n <= 24, 1);
    `CHK(regulator_mode, SSPR_REG_MAIN);
    rd(SSPR_OFS_CTRL, d);
    `CHK(d, 32'h0000_0000);
    $display("standby test done");
  endtask
  // brownout trip, then option reload without and with clamped brownout
  task automatic t_brownout();
    @(posedge clk) supply_mv <= 1700;
    repeat (6) @(posedge clk);
    `CHK({internal_rst, regulator_mode}, 3'b100);
    opt_brownout <= 3'h0;
    supply_mv <= 3300;
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    for (n = 0; n < 300 && internal_rst !== 1'b0; n++) @(negedge clk);
    `CHK(n >= 38 && n <= 48, 1);
    `CHK({brownout_enable, brownout_level}, 4'h0);
    @(posedge clk) opt_brownout <= 3'h7;
    supply_mv <= 1000;
    repeat (6) @(posedge clk);
    `CHK(internal_rst, 1);
    supply_mv <= 3300;
    for (n = 0; n < 300 && internal_rst !== 1'b0; n++) @(negedge clk);
    `CHK(n >= 56 && n <= 66, 1);
    `CHK({brownout_enable, brownout_level}, 4'hd);
    $display("brownout test done");
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_power();
    t_monitor();
    t_stop();
    t_standby();
    t_brownout();
    complete_run();
  end
endmodule
